// ==== shared/sp_pkg.sv ====
// Purpose: Shared constants for the serial shift port.
// Assumes: APB data is 32 bits; every register takes one aligned word.
// Notes: Offsets are byte addresses.
package sp_pkg;

    localparam int SP_ADDR_W = 8;
    localparam int SP_DATA_W = 32;
    localparam int SP_BYTE_W = 8;
    localparam int SP_CNT_W = 4;
    localparam int SP_DIV_W = 10;

    // Register offsets.
    localparam logic [7:0] SP_OFS_CTRL = 8'h00;
    localparam logic [7:0] SP_OFS_STATUS = 8'h04;
    localparam logic [7:0] SP_OFS_BUF = 8'h08;
    localparam logic [7:0] SP_OFS_BAUD = 8'h0C;
    localparam logic [7:0] SP_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] SP_OFS_IRQ_MASK = 8'h14;

    // Control field positions.
    localparam int SP_CTRL_EN = 0;
    localparam int SP_CTRL_MASTER = 1;
    localparam int SP_CTRL_CPOL = 2;
    localparam int SP_CTRL_LEAD = 3;
    localparam int SP_CTRL_RATE_LO = 4;
    localparam int SP_CTRL_RATE_HI = 6;
    localparam int SP_CTRL_SS_USE = 7;
    localparam int SP_CTRL_W = 8;

    // Status field positions.
    localparam int SP_ST_BF = 0;
    localparam int SP_ST_BUSY = 1;

    // Interrupt status field positions.
    localparam int SP_IRQ_DONE = 0;
    localparam int SP_IRQ_WRITE_COLLISION_FLAG = 1;
    localparam int SP_IRQ_W = 2;

    // Reset values.
    localparam logic [7:0] SP_CTRL_RST = 8'h00;
    localparam logic [7:0] SP_BAUD_RST = 8'h00;
    localparam logic [7:0] SP_BUF_RST = 8'h00;
    localparam logic [1:0] SP_IRQ_RST = 2'h0;

    // Bit-rate selections.
    typedef enum logic [2:0] {
        SP_RATE_DIV4 = 3'b000,
        SP_RATE_DIV16 = 3'b001,
        SP_RATE_DIV64 = 3'b010,
        SP_RATE_TMR = 3'b011,
        SP_RATE_BAUD = 3'b100
    } sp_rate_e;

    // Half periods of the serial clock in system clocks (in timer ticks for SP_HALF_TMR), and the last edge index.
    localparam logic [9:0] SP_HALF_DIV4 = 10'h002;
    localparam logic [9:0] SP_HALF_DIV16 = 10'h008;
    localparam logic [9:0] SP_HALF_DIV64 = 10'h020;
    localparam logic [9:0] SP_HALF_TMR = 10'h001;
    localparam logic [3:0] SP_LAST_EDGE = 4'hF;

endpackage : sp_pkg

// ==== src/sp_sync.sv ====
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to pclk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/10ps
module sp_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= INIT;
            dout <= INIT;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end

endmodule : sp_sync

// ==== src/sp_rate_div.sv ====
// Purpose: Divides enable pulses into serial clock half-period ticks.
// Assumes: limit is at least one.
// Notes: clr restarts the count so the first tick is a full half period away.
`timescale 1ns/10ps
module sp_rate_div
    import sp_pkg::*;
#(
    parameter int W = SP_DIV_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic step,
    input wire logic [W-1:0] limit,
    output logic tick
);

    logic [W-1:0] cnt_reg;
    wire logic at_end = (cnt_reg == limit - W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (clr) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (step) begin
            cnt_reg <= at_end ? '0 : cnt_reg + W'(1);
            tick <= at_end;
        end else begin
            tick <= 1'b0;
        end
    end

endmodule : sp_rate_div

// ==== src/sp_shift_port.sv ====
// Purpose: SPI mode of the synchronous serial port with an APB register file.
// Assumes: Pins are asynchronous and pass sp_sync; timer_tick is a pclk pulse.
// Notes: Master and slave share one shift register and one edge counter.
// How it works
// - Eight-bit shift register sends MSB first and takes input into the LSB.
// - Output changes on the configured edge; input is captured on the other.
// - Serial out and serial in are separate pins, data moves both ways.
// - Both ends use the same clock idle polarity setting.
// - After eight clock cycles the shift register holds the partner's byte.
// - Further bytes are sent by reloading the shift register and repeating.
// - A deselected slave ignores the bus and does not drive serial out.
// - A full byte goes to the buffer and sets the irq and full flags.
// - Buffer writes during shifting are dropped and flag a collision.
// - In master mode writing the buffer starts the byte at once.
// - Master rate is clock over 4, 16, 64, timer over 2, or baud.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module sp_shift_port
    import sp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SP_ADDR_W-1:0] paddr,
    input wire logic [SP_DATA_W-1:0] pwdata,
    output logic [SP_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_tick,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_oe,
    output logic irq
);

    logic [SP_CTRL_W-1:0] ctrl_reg;
    logic [SP_BYTE_W-1:0] baud_divisor_reg;
    logic [SP_BYTE_W-1:0] serial_buffer_reg;
    logic [SP_BYTE_W-1:0] serial_shift_reg;
    logic [SP_IRQ_W-1:0] irq_stat_reg;
    logic [SP_IRQ_W-1:0] irq_mask_reg;
    logic [SP_CNT_W-1:0] edge_cnt_reg;
    logic buffer_full_flag_reg;
    logic busy_reg;
    logic sck_prev_reg;
    logic [2:0] pin_s;
    logic tick;
    logic [SP_DIV_W-1:0] half_lim;
    logic msamp_reg;
    logic mdone_reg;

    // Control fields.
    wire logic en = ctrl_reg[SP_CTRL_EN];
    wire logic master = ctrl_reg[SP_CTRL_MASTER];
    wire logic cpol = ctrl_reg[SP_CTRL_CPOL];
    wire logic lead_shift = ctrl_reg[SP_CTRL_LEAD];
    wire logic ss_use = ctrl_reg[SP_CTRL_SS_USE];
    wire logic [2:0] rate = ctrl_reg[SP_CTRL_RATE_HI:SP_CTRL_RATE_LO];
    wire logic port_irq_flag = irq_stat_reg[SP_IRQ_DONE];
    wire logic write_collision_flag = irq_stat_reg[SP_IRQ_WRITE_COLLISION_FLAG];

    // Synchronised pins.
    wire logic sck_s = pin_s[0];
    wire logic sdi_s = pin_s[1];
    wire logic ss_n_s = pin_s[2];

    sp_sync #(.W(3), .INIT(3'b100)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({ss_n_i, sdi_i, sck_i}),
        .dout(pin_s)
    );

    // APB decode.
    wire logic setup = psel & ~penable & ~pready;
    wire logic access = psel & penable & pready;
    wire logic wr = access & pwrite;
    wire logic rd = access & ~pwrite;
    wire logic hit_ctrl = (paddr == SP_OFS_CTRL);
    wire logic hit_stat = (paddr == SP_OFS_STATUS);
    wire logic hit_buf = (paddr == SP_OFS_BUF);
    wire logic hit_baud = (paddr == SP_OFS_BAUD);
    wire logic hit_istat = (paddr == SP_OFS_IRQ_STAT);
    wire logic hit_imask = (paddr == SP_OFS_IRQ_MASK);
    wire logic hit_any = hit_ctrl | hit_stat | hit_buf | hit_baud | hit_istat | hit_imask;

    // Transfer state.
    wire logic slave_sel = ~ss_use | ~ss_n_s;
    wire logic slave_act = en & ~master & slave_sel;
    wire logic xfer_busy = master ? busy_reg : (edge_cnt_reg != '0);

    // Buffer writes: accepted only when idle and no collision is pending.
    wire logic buf_wr = wr & hit_buf;
    wire logic buf_accept = buf_wr & ~xfer_busy & ~write_collision_flag;
    wire logic buf_load = buf_accept & en;
    wire logic start = buf_load & master;
    wire logic write_collision_flag_set = buf_wr & xfer_busy;

    // Edge events: master ticks its own clock, slave follows the pin.
    wire logic sck_edge = sck_s ^ sck_prev_reg;
    wire logic master_edge = en & master & busy_reg & tick & ~mdone_reg;
    wire logic slave_edge = slave_act & sck_edge;
    wire logic edge_evt = master_edge | slave_edge;
    wire logic lead = master ? (sck_o == cpol) : (sck_prev_reg == cpol);
    wire logic sample_evt = edge_evt & (lead ^ lead_shift);
    wire logic shift_evt = edge_evt & ~(lead ^ lead_shift);
    wire logic last_edge = edge_evt & (edge_cnt_reg == SP_LAST_EDGE);
    // Master input lags the pin by the synchroniser, so it is taken one cycle late.
    wire logic samp_now = master ? msamp_reg : sample_evt;
    wire logic done = master ? (mdone_reg & en) : last_edge;
    wire logic [SP_BYTE_W-1:0] shift_in = {serial_shift_reg[SP_BYTE_W-2:0], sdi_s};

    // Bit-rate selection.
    always_comb begin
        case (sp_rate_e'(rate))
            SP_RATE_DIV4: half_lim = SP_HALF_DIV4;
            SP_RATE_DIV16: half_lim = SP_HALF_DIV16;
            SP_RATE_DIV64: half_lim = SP_HALF_DIV64;
            SP_RATE_TMR: half_lim = SP_HALF_TMR;
            SP_RATE_BAUD: half_lim = {1'b0, baud_divisor_reg, 1'b0} + SP_DIV_W'(2);
            default: half_lim = SP_HALF_DIV4;
        endcase
    end

    wire logic div_step = (sp_rate_e'(rate) == SP_RATE_TMR) ? timer_tick : 1'b1;

    sp_rate_div #(.W(SP_DIV_W)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .clr(~busy_reg | start),
        .step(div_step),
        .limit(half_lim),
        .tick(tick)
    );

    // Read data.
    wire logic [SP_DATA_W-1:0] rd_data =
        hit_ctrl ? {24'h000000, ctrl_reg} :
        hit_stat ? {30'h00000000, xfer_busy, buffer_full_flag_reg} :
        hit_buf ? {24'h000000, serial_buffer_reg} :
        hit_baud ? {24'h000000, baud_divisor_reg} :
        hit_istat ? {30'h00000000, irq_stat_reg} :
        hit_imask ? {30'h00000000, irq_mask_reg} : 32'h00000000;

    // APB slave: one wait-free access phase, error on unmapped offsets.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit_any;
            if (setup) begin
                prdata <= rd_data;
            end
        end
    end

    // Software-owned registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= SP_CTRL_RST;
            baud_divisor_reg <= SP_BAUD_RST;
            irq_mask_reg <= SP_IRQ_RST;
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl_reg <= pwdata[SP_CTRL_W-1:0];
            end
            if (hit_baud) begin
                baud_divisor_reg <= pwdata[SP_BYTE_W-1:0];
            end
            if (hit_imask) begin
                irq_mask_reg <= pwdata[SP_IRQ_W-1:0];
            end
        end
    end

    // Sticky event flags: a hardware set wins over a same-cycle clear.
    wire logic [SP_IRQ_W-1:0] irq_clr = (wr & hit_istat) ? pwdata[SP_IRQ_W-1:0] : '0;
    wire logic [SP_IRQ_W-1:0] irq_set = {write_collision_flag_set, done};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= SP_IRQ_RST;
            irq <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Buffer and full flag: received byte lands here, reading clears full.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_buffer_reg <= SP_BUF_RST;
            buffer_full_flag_reg <= 1'b0;
        end else begin
            if (done) begin
                serial_buffer_reg <= samp_now ? shift_in : serial_shift_reg;
            end else if (buf_accept) begin
                serial_buffer_reg <= pwdata[SP_BYTE_W-1:0];
            end
            if (done) begin
                buffer_full_flag_reg <= 1'b1;
            end else if (rd & hit_buf) begin
                buffer_full_flag_reg <= 1'b0;
            end
        end
    end

    // Edge counter and master busy; disable abandons the byte.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt_reg <= '0;
            busy_reg <= 1'b0;
            sck_prev_reg <= 1'b0;
            msamp_reg <= 1'b0;
            mdone_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
            msamp_reg <= master_edge & (lead ^ lead_shift);
            mdone_reg <= master_edge & (edge_cnt_reg == SP_LAST_EDGE);
            if (!en || (!master && !slave_sel)) begin
                edge_cnt_reg <= '0;
            end else if (edge_evt) begin
                edge_cnt_reg <= edge_cnt_reg + SP_CNT_W'(1);
            end
            if (!en || done) begin
                busy_reg <= 1'b0;
            end else if (start) begin
                busy_reg <= 1'b1;
            end
        end
    end

    // Shift register and serial out.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_shift_reg <= SP_BUF_RST;
            sdo_o <= 1'b0;
        end else if (buf_load) begin
            serial_shift_reg <= pwdata[SP_BYTE_W-1:0];
            sdo_o <= pwdata[SP_BYTE_W-1];
        end else if (samp_now) begin
            serial_shift_reg <= shift_in;
        end else if (shift_evt) begin
            sdo_o <= serial_shift_reg[SP_BYTE_W-1];
        end
    end

    // Pin drivers: master clock and select, slave output only when chosen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
            sdo_oe <= 1'b0;
            ss_n_o <= 1'b1;
            ss_oe <= 1'b0;
        end else begin
            if (master_edge) begin
                sck_o <= ~sck_o;
            end else if (!busy_reg) begin
                sck_o <= cpol;
            end
            sck_oe <= en & master;
            sdo_oe <= en & (master | slave_sel);
            ss_n_o <= ~busy_reg;
            ss_oe <= en & master;
        end
    end

    // Checks.
    AST_LOAD_MSB: assert property (
        @(posedge pclk) disable iff (!presetn)
        buf_load |=> sdo_o == $past(pwdata[7]))
        else $error("Loaded byte did not put its top bit on serial out.");

    AST_WRITE_COLLISION_FLAG: assert property (
        @(posedge pclk) disable iff (!presetn)
        buf_wr && xfer_busy && !samp_now
            |=> write_collision_flag && $stable(serial_shift_reg))
        else $error("Write during a byte was not dropped and flagged.");

    AST_WRITE_COLLISION_FLAG_BLOCK: assert property (
        @(posedge pclk) disable iff (!presetn)
        buf_wr && write_collision_flag && !xfer_busy |=> $stable(serial_buffer_reg))
        else $error("Buffer write went through with a collision pending.");

    AST_DONE_FLAGS: assert property (
        @(posedge pclk) disable iff (!presetn)
        done |=> buffer_full_flag_reg && port_irq_flag
            && serial_buffer_reg == $past(samp_now ? shift_in : serial_shift_reg))
        else $error("Finished byte did not reach the buffer with its flags.");

    AST_START: assert property (
        @(posedge pclk) disable iff (!presetn)
        start |=> busy_reg ##1 !ss_n_o)
        else $error("Master did not start on a buffer write.");

    AST_DESEL: assert property (
        @(posedge pclk) disable iff (!presetn)
        en && !master && ss_use && ss_n_s |=> !sdo_oe && edge_cnt_reg == '0)
        else $error("Deselected slave drove serial out or counted edges.");

    AST_DISABLE: assert property (
        @(posedge pclk) disable iff (!presetn)
        !en |=> edge_cnt_reg == '0 && !busy_reg && !sdo_oe)
        else $error("Disabled port kept a partial byte.");

    AST_STOP_ORDER: assert property (
        @(posedge pclk) disable iff (!presetn)
        en && master && done |=> !busy_reg && sck_o == cpol ##1 ss_n_o)
        else $error("Select released before the clock returned to idle.");

    AST_IDLE_SCK: assert property (
        @(posedge pclk) disable iff (!presetn)
        !busy_reg && $stable(cpol) && $past(!busy_reg) |-> sck_o == cpol)
        else $error("Idle serial clock is not at the chosen polarity.");

    AST_EDGE_COUNT: assert property (
        @(posedge pclk) disable iff (!presetn)
        done |-> (master ? ($past(edge_cnt_reg) == 4'hF && $past(edge_evt))
            : (edge_cnt_reg == 4'hF && edge_evt)))
        else $error("Byte finished before sixteen clock edges.");

    AST_DIV4: assert property (
        @(posedge pclk) disable iff (!presetn)
        master_edge && rate == 3'b000 |-> ##1 !tick ##1 (tick || !busy_reg))
        else $error("Fastest rate is not two cycles per half period.");

    AST_SLAVE_NO_CLK: assert property (
        @(posedge pclk) disable iff (!presetn)
        !master |=> !sck_oe)
        else $error("Slave drove the serial clock.");

    AST_SS_IDLE: assert property (
        @(posedge pclk) disable iff (!presetn)
        en && master && !busy_reg |=> ss_n_o)
        else $error("Select held low with no byte in flight.");

    AST_IRQ_LEVEL: assert property (
        @(posedge pclk) disable iff (!presetn)
        (irq_stat_reg & irq_mask_reg) != '0 |=> irq)
        else $error("Unmasked event did not raise the interrupt.");

    AST_FULL_CLEAR: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd && hit_buf && !done |=> !buffer_full_flag_reg)
        else $error("Reading the buffer did not clear the full flag.");

endmodule : sp_shift_port

// ==== testbench/sp_spi_partner.sv ====
// Purpose: SPI slave model that faces the port in master mode.
// Assumes: Clock idles low; data is taken on the rise and moved on the fall.
// Notes: A released miso shows the inverse of its last bit.
`timescale 1ns/10ps
module sp_spi_partner (
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic cap;
    initial miso = 1'h0;
    initial rx_byte = 8'h00;
    always @(negedge ss_n) begin
        rx_byte = tx_byte;
        miso = tx_byte[7];
    end
    always @(posedge sck) begin
        if (!ss_n) cap = mosi;
    end
    always @(negedge sck) begin
        if (!ss_n) begin
            rx_byte = {rx_byte[6:0], cap};
            miso = rx_byte[7];
        end
    end
    always @(posedge ss_n) miso = ~miso;
endmodule : sp_spi_partner

// ==== testbench/tb_sp_shift_port.sv ====
// Purpose: Self-checking bench for the serial shift port.
// Assumes: Clock idles low and data is taken on the rising edge.
// Notes: The bench acts as SPI master in the slave-mode test.
`timescale 1ns/10ps
module tb_sp_shift_port
    import sp_pkg::*;
;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sck_o, sck_oe, sdo_o, sdo_oe, ss_n_o, ss_oe, irq, miso;
    logic timer_tick = 1'h0, sck_m = 1'h0, ss_m = 1'h1, sdi_m = 1'h0, slv = 1'h0, msk = 1'h0;
    logic [7:0] p_tx = 8'h00, p_rx, srx;
    logic [2:0] rts [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    int hv [5] = '{2, 8, 32, 3, 6};
    int err_count = 0, checked = 0, tk = 0;
    wire sck_w = sck_oe ? sck_o : 1'h0;
    wire ss_w = ss_oe ? ss_n_o : 1'h1;
    wire sdo_w = sdo_oe ? sdo_o : ~sdo_o;
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        tk <= (tk == 2) ? 0 : tk + 1;
        timer_tick <= (tk == 2);
    end
    sp_shift_port sp_shift_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
        .sck_i(slv ? sck_m : sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
        .sdi_i(slv ? sdi_m : miso), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .ss_n_i(ss_m), .ss_n_o(ss_n_o), .ss_oe(ss_oe), .irq(irq));
    sp_spi_partner sp_spi_partner_inst (.sck(sck_w), .ss_n(ss_w), .mosi(sdo_w),
        .tx_byte(p_tx), .miso(miso), .rx_byte(p_rx));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) err_count++;
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'h0, a, 32'h0, r, e);
    endtask : rd
    task automatic rdk(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] r;
        rd(a, r);
        chk(nm, e, r);
    endtask : rdk
    task automatic wait_done();
        logic [31:0] r;
        int n;
        n = 0;
        r = 32'h0;
        while (r[SP_ST_BF] !== 1'h1 && n < 400) begin
            rd(SP_OFS_STATUS, r);
            n++;
        end
        chk("done", 32'h1, {31'h0, r[SP_ST_BF]});
    endtask : wait_done
    task automatic mx(input logic [2:0] rt, input logic [7:0] tx, input logic [7:0] ptx,
        input int half);
        int n;
        p_tx = ptx;
        wr(SP_OFS_CTRL, {24'h0, 1'h0, rt, 4'h3});
        wr(SP_OFS_BUF, {24'h0, tx});
        n = 0;
        while (sck_o !== 1'h1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (sck_o === 1'h1 && n < 200);
        chk("half period", half, n);
        wait_done();
        chk("irq", {31'h0, msk}, {31'h0, irq});
        rdk(SP_OFS_BUF, {24'h0, ptx}, "received");
        chk("partner byte", {24'h0, tx}, {24'h0, p_rx});
        rdk(SP_OFS_STATUS, 32'h0, "status");
        rdk(SP_OFS_IRQ_STAT, 32'h1, "irq status");
        wr(SP_OFS_IRQ_STAT, 32'h1);
        rdk(SP_OFS_IRQ_STAT, 32'h0, "irq status clear");
        chk("irq low", 32'h0, {31'h0, irq});
    endtask : mx
    task automatic sx(input logic [7:0] tx, output logic [7:0] rx);
        ss_m <= 1'h0;
        for (int i = 7; i >= 0; i--) begin
            sdi_m <= tx[i];
            repeat (8) @(posedge pclk);
            rx[i] = sdo_o;
            sck_m <= 1'h1;
            repeat (8) @(posedge pclk);
            sck_m <= 1'h0;
        end
        repeat (8) @(posedge pclk);
        ss_m <= 1'h1;
        sdi_m <= ~sdi_m;
    endtask : sx
    task automatic tend(input string nm);
        $display("test %s finished", nm);
    endtask : tend
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    initial begin
        #400000;
        err_count++;
        stop_test();
    end
    initial begin
        logic [31:0] r;
        logic e;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        repeat (3) @(posedge pclk);
        chk("select idle", 32'h1, {31'h0, ss_n_o});
        chk("drive enables", 32'h0, {29'h0, sck_oe, sdo_oe, ss_oe});
        for (int a = 0; a < 6; a++) rdk(8'(a * 4), 32'h0, "reset value");
        apb(1'h0, 8'h18, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        tend("registers");
        wr(SP_OFS_BAUD, 32'h2);
        for (int i = 0; i < 5; i++) begin
            if (i == 2) begin
                wr(SP_OFS_IRQ_MASK, 32'h3);
                msk = 1'h1;
            end
            mx(rts[i], 8'hA5 ^ 8'(i), 8'h3C + 8'(i), hv[i]);
        end
        tend("master rates");
        p_tx = 8'h5A;
        wr(SP_OFS_BUF, 32'h11);
        wr(SP_OFS_BUF, 32'h22);
        wait_done();
        rdk(SP_OFS_BUF, 32'h5A, "collision rx");
        chk("collision tx", 32'h11, {24'h0, p_rx});
        rdk(SP_OFS_IRQ_STAT, 32'h3, "collision flag");
        wr(SP_OFS_BUF, 32'h33);
        rdk(SP_OFS_STATUS, 32'h0, "blocked write");
        wr(SP_OFS_IRQ_STAT, 32'h3);
        repeat (2) @(posedge pclk);
        chk("irq after clear", 32'h0, {31'h0, irq});
        tend("collision");
        p_tx = 8'hC3;
        wr(SP_OFS_CTRL, 32'h13);
        wr(SP_OFS_BUF, 32'h96);
        repeat (40) @(posedge pclk);
        wr(SP_OFS_CTRL, 32'h0);
        rdk(SP_OFS_STATUS, 32'h0, "disabled busy");
        rdk(SP_OFS_IRQ_STAT, 32'h0, "disabled done");
        mx(3'h0, 8'h69, 8'h3C, 2);
        tend("disable");
        slv <= 1'h1;
        wr(SP_OFS_CTRL, 32'h81);
        wr(SP_OFS_BUF, 32'hA7);
        for (int i = 0; i < 4; i++) begin
            sck_m <= ~sck_m;
            sdi_m <= ~sdi_m;
            repeat (4) @(posedge pclk);
            chk("deselected drive", 32'h0, {31'h0, sdo_oe});
        end
        sx(8'h4E, srx);
        chk("slave tx", 32'hA7, {24'h0, srx});
        wait_done();
        rdk(SP_OFS_BUF, 32'h4E, "slave rx");
        tend("slave");
        stop_test();
    end
endmodule : tb_sp_shift_port
